// File: logic/spgm_pkg.sv
package spgm_pkg;
    localparam int NUM_PINS = 37;
    localparam int ADDR_W = 8;
    localparam int B_W = 16;
    localparam int C_W = 12;
    localparam int D_W = 2;
    localparam int E_W = 10;
    localparam int E_OWN_W = 6;
    localparam int SHARE_W = 4;
    // pin vector layout
    localparam int B_LSB = 0;
    localparam int C_LSB = 16;
    localparam int D_LSB = 28;
    localparam int E_LSB = 30;
    localparam int T_PIN = 36;
    // port C bits 8..11 are the pins shared with serial port B bits 6..9
    localparam int C_SHARE_LSB = 8;
    // register byte offsets
    localparam logic [7:0] OFF_HOST_CTRL = 8'h00;
    localparam logic [7:0] OFF_HOST_DIR = 8'h04;
    localparam logic [7:0] OFF_HOST_DATA = 8'h08;
    localparam logic [7:0] OFF_C_CTRL = 8'h0C;
    localparam logic [7:0] OFF_C_DIR = 8'h10;
    localparam logic [7:0] OFF_C_DATA = 8'h14;
    localparam logic [7:0] OFF_D_CTRL = 8'h18;
    localparam logic [7:0] OFF_D_DIR = 8'h1C;
    localparam logic [7:0] OFF_D_DATA = 8'h20;
    localparam logic [7:0] OFF_E_CTRL = 8'h24;
    localparam logic [7:0] OFF_E_DIR = 8'h28;
    localparam logic [7:0] OFF_E_DATA = 8'h2C;
    localparam logic [7:0] OFF_TIMER = 8'h30;
    // host control: bit 0 enable, pin-position bits 9, 10 and 13..15 keep that pin as GPIO
    localparam int HC_EN_BIT = 0;
    localparam logic [15:0] HOST_GPIO_MASK = 16'hE600;
    localparam logic [15:0] HOST_CTRL_WMASK = 16'hE601;
    // timer control/status fields
    localparam int TC_TIMER_BIT = 0;
    localparam int TC_DIR_BIT = 1;
    localparam int TC_DATA_BIT = 2;
    localparam int TC_W = 3;
    localparam logic [15:0] RST_ZERO = 16'h0000;
endpackage

// File: logic/spgm_bank_if.sv
interface spgm_bank_if #(parameter int N = 37);
    logic [N-1:0] drv_out;
    logic [N-1:0] drv_oe;
    logic [N-1:0] pin_in;
    logic [N-1:0] q_out;
    logic [N-1:0] q_oe;
    logic [N-1:0] q_in;
    modport ctrl (output drv_out, output drv_oe, output pin_in,
                  input q_out, input q_oe, input q_in);
    modport bank (input drv_out, input drv_oe, input pin_in,
                  output q_out, output q_oe, output q_in);
endinterface

// File: logic/spgm_pin_bank.sv
module spgm_pin_bank #(
    parameter int N = 37
) (
    input wire logic pclk,
    input wire logic presetn,
    spgm_bank_if.bank bus
);
    // pad stage: every pin leaves and enters through a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.q_out <= '0;
            bus.q_oe <= '0;
            bus.q_in <= '0;
        end else begin
            bus.q_out <= bus.drv_out;
            bus.q_oe <= bus.drv_oe;
            bus.q_in <= bus.pin_in;
        end
    end
endmodule

// File: logic/spgm_top.sv
module spgm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [36:0] pin_in,
    output logic [36:0] pin_out,
    output logic [36:0] pin_oe,
    input wire logic [15:0] host_per_out,
    input wire logic [15:0] host_per_oe,
    output logic [15:0] host_per_in,
    output logic host_port_enabled,
    input wire logic [11:0] asa_per_out,
    input wire logic [11:0] asa_per_oe,
    output logic [11:0] asa_per_in,
    input wire logic [1:0] atx_per_out,
    input wire logic [1:0] atx_per_oe,
    output logic [1:0] atx_per_in,
    input wire logic [9:0] asb_per_out,
    input wire logic [9:0] asb_per_oe,
    output logic [9:0] asb_per_in,
    input wire logic tmr_per_out,
    input wire logic tmr_per_oe,
    output logic tmr_per_in
);
    localparam int SH_HI = spgm_pkg::C_SHARE_LSB + spgm_pkg::SHARE_W - 1;
    localparam int EO_HI = spgm_pkg::E_OWN_W - 1;

    // data read-back: driven bits show the latch, input bits the pin
    function automatic logic [15:0] rd_mix(input logic [15:0] dir,
                                           input logic [15:0] data,
                                           input logic [15:0] pin);
        rd_mix = (dir & data) | (~dir & pin);
    endfunction

    logic [15:0] host_port_control_reg;
    logic [15:0] host_port_direction_reg;
    logic [15:0] host_port_pin_data_reg;
    logic [11:0] portc_control_reg;
    logic [11:0] portc_direction_reg;
    logic [11:0] portc_data_reg;
    logic [1:0] portd_control_reg;
    logic [1:0] portd_direction_reg;
    logic [1:0] portd_data_reg;
    logic [9:0] porte_control_reg;
    logic [9:0] porte_direction_reg;
    logic [9:0] porte_data_reg;
    logic [2:0] timer_control_status_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    spgm_bank_if #(.N(spgm_pkg::NUM_PINS)) bank_bus ();

    spgm_pin_bank #(.N(spgm_pkg::NUM_PINS)) u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .bus(bank_bus)
    );

    wire [36:0] samp = bank_bus.q_in;

    // port B ownership
    wire host_en = host_port_control_reg[spgm_pkg::HC_EN_BIT];
    wire [15:0] b_gpio = host_en
        ? (host_port_control_reg & spgm_pkg::HOST_GPIO_MASK)
        : 16'hFFFF;
    wire [15:0] b_out = (b_gpio & host_port_pin_data_reg)
        | (~b_gpio & host_per_out);
    wire [15:0] b_oe = (b_gpio & host_port_direction_reg)
        | (~b_gpio & host_per_oe);

    // shared pins: serial A, then serial B, then port C GPIO
    // (only while it drives), and port E GPIO last
    wire [3:0] sh_a = portc_control_reg[SH_HI:spgm_pkg::C_SHARE_LSB];
    wire [3:0] sh_b = porte_control_reg[9:6] & ~sh_a;
    wire [3:0] sh_cdir = portc_direction_reg[SH_HI:spgm_pkg::C_SHARE_LSB];
    wire [3:0] sh_e = ~sh_a & ~porte_control_reg[9:6] & ~sh_cdir;
    wire [11:0] sh_b_w = {sh_b, 8'h00};
    wire [11:0] sh_e_w = {sh_e, 8'h00};
    wire [11:0] c_gpio = ~portc_control_reg & ~sh_b_w & ~sh_e_w;
    wire [11:0] c_out = (portc_control_reg & asa_per_out)
        | (c_gpio & portc_data_reg)
        | (sh_b_w & {asb_per_out[9:6], 8'h00})
        | (sh_e_w & {porte_data_reg[9:6], 8'h00});
    wire [11:0] c_oe = (portc_control_reg & asa_per_oe)
        | (c_gpio & portc_direction_reg)
        | (sh_b_w & {asb_per_oe[9:6], 8'h00})
        | (sh_e_w & {porte_direction_reg[9:6], 8'h00});

    // port D
    wire [1:0] d_gpio = ~portd_control_reg;
    wire [1:0] d_out = (portd_control_reg & atx_per_out)
        | (d_gpio & portd_data_reg);
    wire [1:0] d_oe = (portd_control_reg & atx_per_oe)
        | (d_gpio & portd_direction_reg);

    // port E own pins
    wire [5:0] e_per = porte_control_reg[EO_HI:0];
    wire [5:0] e_out = (e_per & asb_per_out[EO_HI:0])
        | (~e_per & porte_data_reg[EO_HI:0]);
    wire [5:0] e_oe = (e_per & asb_per_oe[EO_HI:0])
        | (~e_per & porte_direction_reg[EO_HI:0]);

    // timer pin
    wire t_per = timer_control_status_reg[spgm_pkg::TC_TIMER_BIT];
    wire t_out = t_per ? tmr_per_out
        : timer_control_status_reg[spgm_pkg::TC_DATA_BIT];
    wire t_oe = t_per ? tmr_per_oe
        : timer_control_status_reg[spgm_pkg::TC_DIR_BIT];

    assign bank_bus.drv_out = {t_out, e_out, d_out, c_out, b_out};
    assign bank_bus.drv_oe = {t_oe, e_oe, d_oe, c_oe, b_oe};
    assign bank_bus.pin_in = pin_in;

    // sampled pins per group
    wire [15:0] s_b = samp[15:0];
    wire [11:0] s_c = samp[27:16];
    wire [1:0] s_d = samp[29:28];
    wire [9:0] s_e = {samp[27:24], samp[35:30]};
    wire s_t = samp[spgm_pkg::T_PIN];

    // APB decode
    wire acc = psel & penable & ~pready_reg;
    wire wr_take = psel & penable & pready_reg & pwrite;
    wire hit_hc = (paddr == spgm_pkg::OFF_HOST_CTRL);
    wire hit_hd = (paddr == spgm_pkg::OFF_HOST_DIR);
    wire hit_hx = (paddr == spgm_pkg::OFF_HOST_DATA);
    wire hit_cc = (paddr == spgm_pkg::OFF_C_CTRL);
    wire hit_cd = (paddr == spgm_pkg::OFF_C_DIR);
    wire hit_cx = (paddr == spgm_pkg::OFF_C_DATA);
    wire hit_dc = (paddr == spgm_pkg::OFF_D_CTRL);
    wire hit_dd = (paddr == spgm_pkg::OFF_D_DIR);
    wire hit_dx = (paddr == spgm_pkg::OFF_D_DATA);
    wire hit_ec = (paddr == spgm_pkg::OFF_E_CTRL);
    wire hit_ed = (paddr == spgm_pkg::OFF_E_DIR);
    wire hit_ex = (paddr == spgm_pkg::OFF_E_DATA);
    wire hit_tc = (paddr == spgm_pkg::OFF_TIMER);
    wire hit_any = hit_hc | hit_hd | hit_hx | hit_cc | hit_cd | hit_cx
        | hit_dc | hit_dd | hit_dx | hit_ec | hit_ed | hit_ex | hit_tc;

    wire [15:0] b_rd = rd_mix(host_port_direction_reg,
        host_port_pin_data_reg, s_b);
    wire [15:0] c_rd = rd_mix({4'h0, portc_direction_reg},
        {4'h0, portc_data_reg}, {4'h0, s_c});
    wire [15:0] d_rd = rd_mix({14'h0000, portd_direction_reg},
        {14'h0000, portd_data_reg}, {14'h0000, s_d});
    wire [15:0] e_rd = rd_mix({6'h00, porte_direction_reg},
        {6'h00, porte_data_reg}, {6'h00, s_e});
    wire t_rd = timer_control_status_reg[spgm_pkg::TC_DIR_BIT]
        ? timer_control_status_reg[spgm_pkg::TC_DATA_BIT] : s_t;

    wire [15:0] rd_sel =
        ({16{hit_hc}} & host_port_control_reg)
        | ({16{hit_hd}} & host_port_direction_reg)
        | ({16{hit_hx}} & b_rd)
        | ({16{hit_cc}} & {4'h0, portc_control_reg})
        | ({16{hit_cd}} & {4'h0, portc_direction_reg})
        | ({16{hit_cx}} & c_rd)
        | ({16{hit_dc}} & {14'h0000, portd_control_reg})
        | ({16{hit_dd}} & {14'h0000, portd_direction_reg})
        | ({16{hit_dx}} & d_rd)
        | ({16{hit_ec}} & {6'h00, porte_control_reg})
        | ({16{hit_ed}} & {6'h00, porte_direction_reg})
        | ({16{hit_ex}} & e_rd)
        | ({16{hit_tc}} & {13'h0000, t_rd,
            timer_control_status_reg[1:0]});

    // one wait state keeps pready, prdata and pslverr straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc;
            pslverr_reg <= acc & ~hit_any;
            if (acc) begin
                prdata_reg <= (pwrite | ~hit_any) ? 32'h0000_0000
                    : {16'h0000, rd_sel};
            end
        end
    end

    // host control: soft reset disables the host port, pins fall to GPIO
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_port_control_reg <= spgm_pkg::RST_ZERO;
        end else if (soft_reset) begin
            host_port_control_reg <= spgm_pkg::RST_ZERO;
        end else if (wr_take && hit_hc) begin
            host_port_control_reg <= pwdata[15:0]
                & spgm_pkg::HOST_CTRL_WMASK;
        end
    end

    // direction zero after either reset leaves every port B pin undriven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_port_direction_reg <= spgm_pkg::RST_ZERO;
            host_port_pin_data_reg <= spgm_pkg::RST_ZERO;
        end else if (soft_reset) begin
            host_port_direction_reg <= spgm_pkg::RST_ZERO;
            host_port_pin_data_reg <= spgm_pkg::RST_ZERO;
        end else begin
            if (wr_take && hit_hd) begin
                host_port_direction_reg <= pwdata[15:0];
            end
            if (wr_take && hit_hx) begin
                host_port_pin_data_reg <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portc_control_reg <= 12'h000;
            portc_direction_reg <= 12'h000;
            portc_data_reg <= 12'h000;
            portd_control_reg <= 2'h0;
            portd_direction_reg <= 2'h0;
            portd_data_reg <= 2'h0;
            porte_control_reg <= 10'h000;
            porte_direction_reg <= 10'h000;
            porte_data_reg <= 10'h000;
            timer_control_status_reg <= 3'h0;
        end else if (wr_take) begin
            if (hit_cc) portc_control_reg <= pwdata[11:0];
            if (hit_cd) portc_direction_reg <= pwdata[11:0];
            if (hit_cx) portc_data_reg <= pwdata[11:0];
            if (hit_dc) portd_control_reg <= pwdata[1:0];
            if (hit_dd) portd_direction_reg <= pwdata[1:0];
            if (hit_dx) portd_data_reg <= pwdata[1:0];
            if (hit_ec) porte_control_reg <= pwdata[9:0];
            if (hit_ed) porte_direction_reg <= pwdata[9:0];
            if (hit_ex) porte_data_reg <= pwdata[9:0];
            if (hit_tc) begin
                timer_control_status_reg <= pwdata[2:0];
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pin_out = bank_bus.q_out;
    assign pin_oe = bank_bus.q_oe;
    assign host_port_enabled = host_en;
    assign host_per_in = s_b;
    assign asa_per_in = s_c;
    assign atx_per_in = s_d;
    assign asb_per_in = s_e;
    assign tmr_per_in = s_t;
endmodule

// File: tb/spgm_board.sv
module spgm_board (
    input wire logic pclk,
    input wire logic [36:0] pin_out,
    input wire logic [36:0] pin_oe,
    input wire logic [36:0] ext_val,
    input wire logic [36:0] ext_en,
    output logic [36:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released, undriven pad must never look like a steady level
    logic [36:0] wig = 37'h0;
    always @(posedge pclk) begin
        wig <= ~wig;
    end
    // device drive wins, else board level, else a toggling float
    assign pin_in = (pin_oe & pin_out) |
        (~pin_oe & ((ext_en & ext_val) | (~ext_en & wig)));
endmodule

// File: tb/spgm_top_sva.sv
module spgm_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [36:0] pin_in,
    input wire logic [36:0] pin_oe,
    input wire logic [15:0] host_per_oe,
    input wire logic [15:0] host_per_in,
    input wire logic [9:0] asb_per_in,
    input wire logic [11:0] asa_per_in,
    input wire logic [1:0] atx_per_in,
    input wire logic tmr_per_in,
    input wire logic host_port_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    logic chg_q;
    logic up_q;
    // a register write or soft reset reaches the pads one edge late
    wire quiet = !pready && !soft_reset && !chg_q;
    wire acc = psel && penable && !pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= 1'b0;
            up_q <= 1'b0;
        end else begin
            chg_q <= pready | soft_reset;
            up_q <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_gpio: assert property (
        $rose(presetn) |-> pin_oe == 37'h0 && !host_port_enabled)
        else $error("pins driven after reset");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
    a_unmapped_err: assert property (
        acc && paddr > 8'h33 |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        acc && paddr <= 8'h30 && paddr[1:0] == 2'b00 |=> pready && !pslverr)
        else $error("mapped access not answered");
    a_write_zero: assert property (
        pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    a_host_hold: assert property (
        !host_port_enabled && quiet |=> $stable(pin_oe[15:0]))
        else $error("port B moved while host port off");
    a_host_keep: assert property (
        host_port_enabled && quiet |=> {pin_oe[12:11], pin_oe[8:0]} ==
        $past({host_per_oe[12:11], host_per_oe[8:0]}))
        else $error("host pin not owned by host port");
    a_pin_sample: assert property (
        up_q |=> host_per_in == $past(pin_in[15:0]) &&
        asb_per_in == $past({pin_in[27:24], pin_in[35:30]}))
        else $error("pin samples wrong");
    a_group_sample: assert property (
        up_q |=> asa_per_in == $past(pin_in[27:16]) &&
        atx_per_in == $past(pin_in[29:28]) &&
        tmr_per_in == $past(pin_in[36]))
        else $error("port C, D or timer samples wrong");
endmodule
bind spgm_top spgm_chk chk_u (.pclk, .presetn, .soft_reset, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pin_in,
    .pin_oe, .host_per_oe, .host_per_in, .asb_per_in, .host_port_enabled,
    .asa_per_in, .atx_per_in, .tmr_per_in);

// File: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [36:0] pin_in, pin_out, pin_oe, ext_val, ext_en;
    logic [15:0] host_per_out, host_per_oe;
    logic [11:0] asa_per_out, asa_per_oe;
    logic [1:0] atx_per_out, atx_per_oe;
    logic [9:0] asb_per_out, asb_per_oe;
    logic tmr_per_out, tmr_per_oe, host_port_enabled, last_err;
    int fail_count, comparisons;
    spgm_top dut_u (.pclk, .presetn, .soft_reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
        .pin_oe, .host_per_out, .host_per_oe, .host_per_in(),
        .host_port_enabled, .asa_per_out, .asa_per_oe, .asa_per_in(),
        .atx_per_out, .atx_per_oe, .atx_per_in(), .asb_per_out, .asb_per_oe,
        .asb_per_in(), .tmr_per_out, .tmr_per_oe, .tmr_per_in());
    spgm_board board_u (.pclk, .pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic summarize();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [36:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1, "no pready");
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 0);
        chk(rd, e, "read data");
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask
    // undriven data pins read the board level
    function automatic logic [31:0] rst_exp(input int a);
        case (a)
            'h08: return ext_val[15:0];
            'h14: return ext_val[27:16];
            'h20: return ext_val[29:28];
            'h2C: return {ext_val[27:24], ext_val[35:30]};
            'h30: return {ext_val[36], 2'b00};
            default: return 32'h0;
        endcase
    endfunction
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        $display("Error %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        {presetn, soft_reset, psel, penable, pwrite, paddr, pwdata} = '0;
        {host_per_out, host_per_oe, asa_per_out, asa_per_oe} = '0;
        {atx_per_out, atx_per_oe, asb_per_out, asb_per_oe} = '0;
        {tmr_per_out, tmr_per_oe} = '0;
        ext_val = 37'h1A5C396E1B;
        ext_en = 37'h1FFFFFFFFF;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk(pin_oe, 37'h0, "reset oe");
        chk(host_port_enabled, 1'b0, "host off");
        for (int a = 0; a <= 'h30; a += 4) rdchk(a[7:0], rst_exp(a));
        $display("test reset done");
        host_per_oe <= 16'h0F0F;
        host_per_out <= 16'h3C3C;
        apb(1, 8'h04, 'hFFFF);
        apb(1, 8'h08, 'hA55A);
        settle();
        chk(pin_oe[15:0], 16'hFFFF, "B oe");
        chk(pin_out[15:0], 16'hA55A, "B out");
        rdchk(8'h08, 32'hA55A);
        apb(1, 8'h00, 'hFFFF);
        rdchk(8'h00, 32'hE601);
        settle();
        chk(pin_oe[15:0], 16'hEF0F, "host oe");
        chk(pin_out[15:0], 16'hBC3C, "host out");
        apb(1, 8'h00, 1);
        settle();
        chk(pin_oe[15:0], 16'h0F0F, "host only");
        $display("test port B done");
        asa_per_oe <= 12'hFFF;
        asa_per_out <= 12'h205;
        atx_per_oe <= 2'b11;
        apb(1, 8'h0C, 'h00F);
        apb(1, 8'h10, 'hFF0);
        apb(1, 8'h14, 'hA50);
        apb(1, 8'h18, 1);
        apb(1, 8'h1C, 2);
        apb(1, 8'h20, 2);
        settle();
        chk(pin_oe[29:16], 14'h3FFF, "CD oe");
        chk(pin_out[29:16], 14'h2A55, "CD out");
        @(posedge pclk) soft_reset <= 1'b1;
        @(posedge pclk) soft_reset <= 1'b0;
        settle();
        chk(host_port_enabled, 1'b0, "soft off");
        chk(pin_oe[29:0], 30'h3FFF0000, "soft pins");
        rdchk(8'h04, 32'h0);
        $display("test ports C D done");
        asb_per_oe <= 10'h3FF;
        asb_per_out <= 10'h155;
        apb(1, 8'h10, 'h0F0);
        apb(1, 8'h24, 'h083);
        apb(1, 8'h28, 'h3FC);
        apb(1, 8'h2C, 'h2A8);
        settle();
        chk(pin_oe[35:24], 12'hFFF, "E oe");
        chk(pin_out[35:24], 12'hA68, "E out");
        apb(1, 8'h0C, 'h20F);
        settle();
        chk(pin_out[27:24], 4'hA, "shared prio");
        rdchk(8'h2C, 32'h2A9);
        $display("test port E done");
        apb(1, 8'h30, 6);
        settle();
        chk({pin_oe[36], pin_out[36]}, 2'b11, "tmr gpio");
        tmr_per_oe <= 1'b1;
        apb(1, 8'h30, 1);
        settle();
        chk({pin_oe[36], pin_out[36]}, 2'b10, "tmr func");
        apb(1, 8'h30, 0);
        rdchk(8'h30, 32'h4);
        $display("test timer done");
        apb(1, 8'h34, 'hFFFF);
        chk(last_err, 1'b1, "wr refuse");
        rdchk(8'h34, 32'h0);
        chk(last_err, 1'b1, "rd refuse");
        $display("test unmapped done");
        summarize();
    end
endmodule
